// File: hdl/ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ====================================================================
// Clock
`define SSP_CLK_HZ 20000000
`define SSP_CLK_NS 50

// ====================================================================
// Bus time-out, window of 25 to 35 ms; the count uses the least time
`define SSP_BUS_TIMEOUT_INTERVAL_MIN_MS 25
`define SSP_BUS_TIMEOUT_INTERVAL_MAX_MS 35
`define SSP_BUS_TIMEOUT_INTERVAL_CYC ((`SSP_BUS_TIMEOUT_INTERVAL_MIN_MS * `SSP_CLK_HZ) / 1000)

// ====================================================================
// Data out hold after the clock falls, rounded up to whole cycles
`define SSP_THD_NS 200
`define SSP_THD_CYC ((`SSP_THD_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)

// ====================================================================
// Address and framing
`define SSP_ADDR_HI 4'h3
`define SSP_BYTE_BITS 4'h8
`define SSP_SYNC_INIT 5'h18

`endif

// File: hdl/ssp_pkg.sv
package ssp_pkg;

  // ==================================================================
  // Port sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RX       = 3'h2,
    ST_RX_ACK   = 3'h6,
    ST_TX       = 3'h7,
    ST_TX_ACK   = 3'h5,
    ST_LOCK     = 3'h4
  } ssp_state_e;

  // ==================================================================
  // Received byte handed to the user side
  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic first;
  } ssp_rx_s;

endpackage

// File: hdl/ssp_sync.sv
`timescale 1ns/10ps
module ssp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] din, // Asynchronous inputs.
  output logic [WIDTH-1:0] dout // Synchronised inputs.
);

  logic [WIDTH-1:0] meta;

  // ==================================================================
  // Two flops per bit; the first is read by the second only.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          meta[i] <= INIT[i];
          dout[i] <= INIT[i];
        end else begin
          meta[i] <= din[i];
          dout[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

// File: hdl/ssp_top.sv
`timescale 1ns/10ps
`include "ssp_consts.svh"
// How it works
// - Clock stuck low past the time-out aborts and resets the port.
// - The port never pulls the clock low; the controller owns every phase.
// - A transmitted bit is on the data line well before the clock rises.
// - A transmitted bit is held at least 200 ns after the clock falls.
// - Received data is sampled on the rising clock edge, never the falling one.
// - The three low address bits come from the strap pins, bit 2 on top.
// - A strap tied high reads as 1, tied low reads as 0.
// - An open strap is pulled down and so reads as 0.
// - Data line is open drain: pulled low or released, never driven high.
// - Clock stuck high past the time-out also resets the port.
// - Acknowledge only 0011 plus straps; eighth bit 1 reads, 0 writes.
// - A START or STOP seen mid-transfer releases the data line at once.
module ssp_top #(
  parameter int TIMEOUT_CYCLES = `SSP_BUS_TIMEOUT_INTERVAL_CYC
) (
  input wire logic clock, // System clock, 20 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic scl_in, // Serial clock pin level.
  output logic scl_out, // Serial clock pin output value.
  output logic scl_oe_n, // Serial clock pin enable, low drives.
  input wire logic sda_in, // Serial data pin level.
  output logic sda_out, // Serial data pin output value.
  output logic sda_oe_n, // Serial data pin enable, low drives.
  input wire logic addr_strap_bit0, // Address strap, bit 0.
  input wire logic addr_strap_bit1, // Address strap, bit 1.
  input wire logic addr_strap_bit2, // Address strap, bit 2.
  input wire logic [7:0] tx_data, // Byte to send, taken on tx_take.
  output logic tx_take, // Pulse: tx_data is sampled this cycle.
  output ssp_pkg::ssp_rx_s rx, // Received byte with valid pulse.
  output logic selected, // Port is addressed and in a transfer.
  output logic read_mode, // Last match was a read.
  output logic timeout, // Pulse: bus time-out fired.
  output logic locked // Waiting for START after a time-out.
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TLIM = TW'(TIMEOUT_CYCLES - 1);
  localparam logic [2:0] HOLD = 3'(`SSP_THD_CYC);

  // ==================================================================
  // Pin synchronisers and edge detection
  logic [4:0] syn;
  logic scl_s, sda_s, scl_q, sda_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [6:0] my_addr;

  ssp_sync #(.WIDTH(5), .INIT(`SSP_SYNC_INIT)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .din({scl_in, sda_in, addr_strap_bit2, addr_strap_bit1,
          addr_strap_bit0}),
    .dout(syn)
  );

  assign scl_s = syn[4];
  assign sda_s = syn[3];
  // Straps are plain levels; the pad pull-down makes an open one a 0.
  assign my_addr = {`SSP_ADDR_HI, syn[2], syn[1], syn[0]};

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

  // ==================================================================
  // Sequencer state
  ssp_pkg::ssp_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] txsh, next_txsh;
  logic rw, next_rw;
  logic mack, next_mack;
  logic pend, next_pend;
  logic sda_low, next_sda_low;
  logic [2:0] hcnt, next_hcnt;
  logic [TW-1:0] tcnt, next_tcnt;
  logic first, next_first;
  ssp_pkg::ssp_rx_s next_rx;
  logic next_timeout;
  logic load_tx;
  logic busy;

  assign busy = (state != ssp_pkg::ST_IDLE) && (state != ssp_pkg::ST_LOCK);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_txsh = txsh;
    next_rw = rw;
    next_mack = mack;
    next_pend = pend;
    next_sda_low = sda_low;
    next_hcnt = hcnt;
    next_tcnt = tcnt;
    next_first = first;
    next_rx = rx;
    next_rx.valid = 1'b0;
    next_timeout = 1'b0;
    load_tx = 1'b0;

    // The changed bit only reaches the pin once the hold has run out.
    if (hcnt != 3'h0) begin
      next_hcnt = hcnt - 3'h1;
      if (hcnt == 3'h1) begin
        next_sda_low = pend;
      end
    end

    // Any clock edge restarts the watch for a clock stuck low or high.
    if (!busy || scl_rise || scl_fall) begin
      next_tcnt = '0;
    end else begin
      next_tcnt = TW'(tcnt + 1'b1);
    end

    if (busy && tcnt == TLIM) begin
      next_timeout = 1'b1;
      next_state = ssp_pkg::ST_LOCK;
      next_sda_low = 1'b0;
      next_hcnt = 3'h0;
      next_pend = 1'b0;
      next_tcnt = '0;
    end else if (start_c) begin
      next_state = ssp_pkg::ST_ADDR;
      next_cnt = 4'h0;
      next_sda_low = 1'b0;
      next_hcnt = 3'h0;
      // A stale bit from a cut transfer must not reach the address phase.
      next_pend = 1'b0;
      next_first = 1'b1;
    end else if (stop_c) begin
      if (state != ssp_pkg::ST_LOCK) begin
        next_state = ssp_pkg::ST_IDLE;
      end
      next_sda_low = 1'b0;
      next_hcnt = 3'h0;
      next_pend = 1'b0;
    end else if (scl_rise && busy) begin
      // Data is taken on the rising edge, where it is known to be stable.
      next_shreg = {shreg[6:0], sda_s};
      if (cnt != `SSP_BYTE_BITS) begin
        next_cnt = cnt + 4'h1;
      end
      if (state == ssp_pkg::ST_TX_ACK) begin
        next_mack = ~sda_s;
      end
    end else if (scl_fall && busy) begin
      next_hcnt = HOLD;
      unique case (state)
        ssp_pkg::ST_ADDR: begin
          if (cnt == `SSP_BYTE_BITS) begin
            next_cnt = 4'h0;
            if (shreg[7:1] == my_addr) begin
              next_state = ssp_pkg::ST_ADDR_ACK;
              next_rw = shreg[0];
              next_pend = 1'b1;
            end else begin
              next_state = ssp_pkg::ST_IDLE;
              next_pend = 1'b0;
            end
          end
        end
        ssp_pkg::ST_ADDR_ACK: begin
          next_cnt = 4'h0;
          if (rw) begin
            load_tx = 1'b1;
            next_txsh = tx_data;
            next_pend = ~tx_data[7];
            next_state = ssp_pkg::ST_TX;
          end else begin
            next_pend = 1'b0;
            next_state = ssp_pkg::ST_RX;
          end
        end
        ssp_pkg::ST_RX: begin
          if (cnt == `SSP_BYTE_BITS) begin
            next_cnt = 4'h0;
            next_rx.data = shreg;
            next_rx.valid = 1'b1;
            next_rx.first = first;
            next_first = 1'b0;
            next_pend = 1'b1;
            next_state = ssp_pkg::ST_RX_ACK;
          end
        end
        ssp_pkg::ST_RX_ACK: begin
          next_cnt = 4'h0;
          next_pend = 1'b0;
          next_state = ssp_pkg::ST_RX;
        end
        ssp_pkg::ST_TX: begin
          if (cnt == `SSP_BYTE_BITS) begin
            next_cnt = 4'h0;
            next_pend = 1'b0;
            next_state = ssp_pkg::ST_TX_ACK;
          end else begin
            next_txsh = {txsh[6:0], 1'b0};
            next_pend = ~txsh[6];
          end
        end
        ssp_pkg::ST_TX_ACK: begin
          next_cnt = 4'h0;
          if (mack) begin
            load_tx = 1'b1;
            next_txsh = tx_data;
            next_pend = ~tx_data[7];
            next_state = ssp_pkg::ST_TX;
          end else begin
            // A missing acknowledge ends the read; the line stays free.
            next_pend = 1'b0;
            next_state = ssp_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = ssp_pkg::ST_IDLE;
          next_pend = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ssp_pkg::ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      pend <= 1'b0;
      sda_low <= 1'b0;
      hcnt <= 3'h0;
      tcnt <= '0;
      first <= 1'b0;
      rx <= '0;
      timeout <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      txsh <= next_txsh;
      rw <= next_rw;
      mack <= next_mack;
      pend <= next_pend;
      sda_low <= next_sda_low;
      hcnt <= next_hcnt;
      tcnt <= next_tcnt;
      first <= next_first;
      rx <= next_rx;
      timeout <= next_timeout;
    end
  end

  // ==================================================================
  // Pins and status
  // Both lines are open drain; the data line is only ever pulled low.
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_low;
  assign scl_out = 1'b0;
  assign scl_oe_n = 1'b1;
  assign tx_take = load_tx;
  assign selected = (state != ssp_pkg::ST_IDLE) &&
                    (state != ssp_pkg::ST_LOCK) &&
                    (state != ssp_pkg::ST_ADDR);
  assign read_mode = rw;
  assign locked = (state == ssp_pkg::ST_LOCK);

endmodule

// File: verif/ssp_top_sva.sv
`timescale 1ns/10ps
module ssp_top_sva #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic clock, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic scl_in, // Serial clock pin level.
  input wire logic scl_oe_n, // Serial clock pin enable.
  input wire logic sda_in, // Serial data pin level.
  input wire logic sda_out, // Serial data pin value.
  input wire logic sda_oe_n, // Serial data pin enable.
  input wire logic tx_take, // Transmit byte load pulse.
  input ssp_pkg::ssp_rx_s rx, // Received byte.
  input wire logic selected, // Port addressed.
  input wire logic read_mode, // Last match was a read.
  input wire logic timeout, // Time-out pulse.
  input wire logic locked // Waiting for START.
);
  // ==================================================================
  // Quiet time of the raw clock pin
  int quiet;
  int next_quiet;
  logic scl_q;
  always_comb begin
    next_quiet = (!reset_n || scl_in != scl_q) ? 0 : quiet + 1;
  end
  always_ff @(posedge clock) begin
    scl_q <= scl_in;
    quiet <= next_quiet;
  end
  // ==================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  scl_free_a: assert property (scl_oe_n)
    else $error("clock pin driven");
  sda_od_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  hold_out_a: assert property ($fell(scl_in) |=>
    $stable(sda_oe_n)[*4])
    else $error("data changed too soon after clock fall");
  high_pull_a: assert property ($changed(sda_oe_n) && scl_in |->
    sda_oe_n)
    else $error("data pulled low while clock high");
  cond_release_a: assert property (scl_in && $past(scl_in) && $changed(sda_in)
    |-> ##[1:6] sda_oe_n)
    else $error("line kept after start or stop");
  bus_timeout_interval_time_a: assert property (timeout |-> quiet >= TIMEOUT_CYCLES &&
    quiet <= TIMEOUT_CYCLES + 6)
    else $error("time-out at wrong moment");
  bus_timeout_interval_lock_a: assert property (timeout |=> locked && sda_oe_n)
    else $error("time-out did not lock and release");
  lock_quiet_a: assert property (locked |-> !selected && !tx_take)
    else $error("activity while locked");
  take_read_a: assert property (tx_take |-> read_mode && !scl_in)
    else $error("byte taken outside a read");
  rx_write_a: assert property (rx.valid |-> !read_mode ##1 !rx.valid)
    else $error("received byte outside a write");
  cover property (timeout);
  cover property (rx.valid && rx.first);
  cover property (tx_take);
endmodule

// File: verif/ssp_ctrl_model.sv
`timescale 1ns/10ps
module ssp_ctrl_model (
  input wire logic clock, // Bench clock pacing the bus.
  input wire logic sda, // Data wire level.
  output logic scl, // Serial clock.
  output logic sda_n // Low pulls the data wire down.
);
  // ==================================================================
  // Bus phases
  // The clock moves only inside frames, at 1 MHz, the fastest class.
  initial begin
    scl = 1'b1;
    sda_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Data changes 100 ns into the low phase, sampled half way through the high.
  task automatic bit_x(input logic b, output logic r);
    wt(2);
    sda_n <= b;
    wt(12);
    scl <= 1'b1;
    wt(3);
    r = sda;
    wt(3);
    scl <= 1'b0;
  endtask
  task automatic start();
    wt(2);
    sda_n <= 1'b1;
    // A repeated START waits a full low phase so the port's hold has ended.
    wt(12);
    scl <= 1'b1;
    wt(6);
    sda_n <= 1'b0;
    wt(6);
    scl <= 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_n <= 1'b0;
    wt(12);
    scl <= 1'b1;
    wt(6);
    sda_n <= 1'b1;
    wt(6);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ai,
                        output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ai, ao);
  endtask
  task automatic park(input logic lvl, input int n);
    wt(14);
    scl <= lvl;
    wt(n);
  endtask
endmodule

// File: verif/sensor_serial_slave_port_bench.sv
`timescale 1ns/10ps
module sensor_serial_slave_port_bench;
  localparam int BUS_TIMEOUT_INTERVAL = 200;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [7:0] tx_data = 8'h00;
  logic scl, scl_w, scl_out, scl_oe_n, sda_n, sda, sda_out, sda_oe_n;
  logic tx_take, selected, read_mode, timeout, locked, a;
  ssp_pkg::ssp_rx_s rx;
  logic [7:0] rx_last = 8'h00;
  logic [7:0] q;
  logic rx_first = 1'b0;
  logic bus_timeout_interval_seen = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clock = ~clock;
  // Both wires have pull-ups; each party can only pull low.
  assign scl_w = scl & (scl_oe_n | scl_out);
  assign sda = sda_n & (sda_oe_n | sda_out);
  ssp_top #(.TIMEOUT_CYCLES(BUS_TIMEOUT_INTERVAL)) u_dut (.clock(clock), .reset_n(reset_n),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .tx_data(tx_data), .tx_take(tx_take), .rx(rx), .selected(selected),
    .read_mode(read_mode), .timeout(timeout), .locked(locked));
  ssp_ctrl_model u_ctl (.clock(clock), .sda(sda), .scl(scl), .sda_n(sda_n));
  // ==================================================================
  // Monitors, checks and closing
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rx.valid === 1'b1) begin
      rx_last <= rx.data;
      rx_first <= rx.first;
    end
    if (timeout === 1'b1) begin
      bus_timeout_interval_seen <= 1'b1;
    end
    if (cycles == 20000) begin
      err_count = err_count + 1;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic addr(input logic [2:0] s, input logic rw, input logic ea);
    u_ctl.start();
    u_ctl.byte_x({4'h3, s, rw}, 1'b1, q, a);
    chk("address ack", {7'h0, a}, {7'h0, ea});
  endtask
  // ==================================================================
  // Scenarios
  task automatic t_straps();
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      u_ctl.wt(4);
      addr(3'(s), 1'b0, 1'b0);
      u_ctl.stop();
      addr(3'(s) ^ 3'h2, 1'b0, 1'b1);
      u_ctl.stop();
    end
  endtask
  task automatic t_write();
    addr(3'h7, 1'b0, 1'b0);
    chk("selected", {7'h0, selected}, 8'h01);
    u_ctl.byte_x(8'ha5, 1'b1, q, a);
    chk("write ack", {7'h0, a}, 8'h00);
    chk("rx data", rx_last, 8'ha5);
    chk("rx first", {7'h0, rx_first}, 8'h01);
    u_ctl.byte_x(8'h5a, 1'b1, q, a);
    chk("rx data", rx_last, 8'h5a);
    chk("rx first", {7'h0, rx_first}, 8'h00);
    chk("read mode", {7'h0, read_mode}, 8'h00);
    u_ctl.stop();
  endtask
  task automatic t_read();
    tx_data <= 8'h3c;
    addr(3'h7, 1'b1, 1'b0);
    chk("read mode", {7'h0, read_mode}, 8'h01);
    u_ctl.byte_x(8'hff, 1'b0, q, a);
    tx_data <= 8'hc1;
    chk("read byte", q, 8'h3c);
    u_ctl.byte_x(8'hff, 1'b1, q, a);
    chk("read byte", q, 8'hc1);
    u_ctl.stop();
    chk("selected", {7'h0, selected}, 8'h00);
  endtask
  task automatic t_restart();
    tx_data <= 8'h80;
    addr(3'h7, 1'b1, 1'b0);
    addr(3'h7, 1'b0, 1'b0);
    chk("read mode", {7'h0, read_mode}, 8'h00);
    chk("selected", {7'h0, selected}, 8'h01);
    u_ctl.stop();
  endtask
  task automatic t_bus_timeout_interval(input logic hi);
    bus_timeout_interval_seen <= 1'b0;
    addr(3'h7, 1'b0, 1'b0);
    u_ctl.park(hi, BUS_TIMEOUT_INTERVAL + 40);
    chk("time-out", {7'h0, bus_timeout_interval_seen}, 8'h01);
    chk("locked", {7'h0, locked}, 8'h01);
    if (!hi) begin
      u_ctl.byte_x({4'h3, 3'h7, 1'b0}, 1'b1, q, a);
      chk("locked ack", {7'h0, a}, 8'h01);
    end
    addr(3'h7, 1'b0, 1'b0);
    chk("locked", {7'h0, locked}, 8'h00);
    u_ctl.stop();
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("idle release", {7'h0, sda_oe_n}, 8'h01);
    chk("idle lock", {7'h0, locked}, 8'h00);
    t_straps();
    t_write();
    t_read();
    t_restart();
    t_bus_timeout_interval(1'b0);
    t_bus_timeout_interval(1'b1);
    end_sim();
  end
endmodule
bind ssp_top ssp_top_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (
  .clock(clock), .reset_n(reset_n), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .tx_take(tx_take), .rx(rx), .selected(selected), .read_mode(read_mode),
  .timeout(timeout), .locked(locked));
